/* File: rtl/eep_array.sv */
`timescale 1ns/1ps
`include "eep_consts.svh"

module eep_array #(
	parameter int AW = `EEP_OFFS_W,
	parameter int BW = `EEP_BLOCK_W
) (
	// Clock and power-on
	input  wire logic             clk,
	input  wire logic             por,
	// Read side
	input  wire logic [AW-1:0]    rdOffs,
	output logic [7:0]            rdData,
	// Program and erase side
	input  wire logic             apply,
	input  wire eep_pkg::eep_op_t op,
	input  wire logic [AW-1:0]    offs,
	input  wire logic [7:0]       data
);

	logic [7:0] mem [0:(1<<AW)-1];

	assign rdData = mem[rdOffs];

	// Storage survives rst; only power-on gives it a defined start
	// Every operation is idempotent, so applying it each high-voltage cycle is safe
	always_ff @(posedge clk) begin
		if (por) begin
			for (int i = 0; i < (1<<AW); i++) begin
				mem[i] <= `EEP_BYTE_ERASED;
			end
		end else if (apply) begin
			case (op)
				eep_pkg::EEP_OP_PROGRAM: begin
					mem[offs] <= mem[offs] & data; // see (RULE5)
				end
				eep_pkg::EEP_OP_BYTE_ERASE: begin
					mem[offs] <= `EEP_BYTE_ERASED;
				end
				eep_pkg::EEP_OP_BLOCK_ERASE: begin
					for (int i = 0; i < (1<<AW); i++) begin
						if ((i >> BW) == int'(offs >> BW)) begin
							mem[i] <= `EEP_BYTE_ERASED; // see (RULE21)
						end
					end
				end
				eep_pkg::EEP_OP_BULK_ERASE: begin
					for (int i = 0; i < (1<<AW); i++) begin
						mem[i] <= `EEP_BYTE_ERASED;
					end
				end
				default: begin
				end
			endcase
		end
	end

endmodule

/* File: rtl/eep_consts.svh */
`ifndef EEP_CONSTS_SVH
`define EEP_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register addresses on the plain register port
`define EEP_ADDR_NV        16'hfe18
`define EEP_ADDR_CTRL      16'hfe19
`define EEP_ADDR_SHADOW    16'hfe1b

////////////////////////////////////////////////////////////////////////////////
// Array geometry
`define EEP_ARRAY_BASE     16'h0600
`define EEP_OFFS_W         9
`define EEP_BLOCK_W        7
`define EEP_SECURE_W       4

////////////////////////////////////////////////////////////////////////////////
// Control register fields
`define EEP_CTRL_PCS       7
`define EEP_CTRL_OFF       5
`define EEP_CTRL_ERH       4
`define EEP_CTRL_ERL       3
`define EEP_CTRL_LAT       2
`define EEP_CTRL_HV        0

////////////////////////////////////////////////////////////////////////////////
// Nonvolatile configuration byte fields
`define EEP_NV_RSVD        7
`define EEP_NV_CFGH        6
`define EEP_NV_CFGL        5
`define EEP_NV_LOCK        4
`define EEP_NV_BPH         3
`define EEP_NV_BPL         0

////////////////////////////////////////////////////////////////////////////////
// Reset and erased values
`define EEP_CTRL_RESET     8'h00
`define EEP_NV_ERASED      8'h7f
`define EEP_BYTE_ERASED    8'hff
`define EEP_RD_IDLE        8'h00

`endif

/* File: rtl/eep_pkg.sv */
`include "eep_consts.svh"

package eep_pkg;

	// Order gives the erase select encoding 00..11
	typedef enum logic [1:0] {
		EEP_OP_PROGRAM,
		EEP_OP_BYTE_ERASE,
		EEP_OP_BLOCK_ERASE,
		EEP_OP_BULK_ERASE
	} eep_op_t;

	typedef struct packed {
		logic                   isNv;
		logic [`EEP_OFFS_W-1:0] offs;
		logic [7:0]             data;
	} eep_wr_t;

endpackage

/* File: rtl/eep_prog_erase_ctrl.sv */
// Notes on behaviour
// (RULE1) Pump clock select set uses bus clock, clear uses RC oscillator; reset clears.
// (RULE2) Software should pick the RC oscillator below 8 MHz bus clock.
// (RULE3) Power-down bit disables the array; reads undefined; reset clears it.
// (RULE4) Software waits a recovery time after clearing power-down.
// (RULE5) Erase select 00 program, 01 byte, 10 block, 11 bulk; reset clears.
// (RULE6) A protected block never sees program or erase.
// (RULE7) Latch bit set captures a write for programming; reset clears.
// (RULE8) Latch bit cannot clear while high-voltage enable is set.
// (RULE9) High voltage only with latch set and a valid write latched.
// (RULE10) Clearing latch and high-voltage together clears only high-voltage.
// (RULE11) Config byte: bit 7 reserved reads 0, 6..5 spare, 4 lock, 3..0 protect.
// (RULE12) Reset copies the config byte into the shadow register.
// (RULE13) Lock bit at 0 protects top 16 bytes forever.
// (RULE14) Wait mode leaves program or erase running.
// (RULE15) Software may power down an idle array before wait.
// (RULE16) Stop removes high voltage but keeps the enable; leaving stop restores it.
// (RULE17) Software avoids stop with high voltage on and extends timing.
// (RULE18) Software waits a recovery time after leaving stop.
// (RULE19) While latched, array reads return the latched data.
// (RULE20) Each config byte read reloads the shadow register.
// (RULE21) Four 128-byte blocks, each with its own protect bit.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`include "eep_consts.svh"

module eep_prog_erase_ctrl #(
	parameter int AW = `EEP_OFFS_W,
	parameter int BW = `EEP_BLOCK_W
) (
	// Clock and resets
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        por,
	// Register port
	input  wire logic [15:0] busAddr,
	input  wire logic [7:0]  busWdata,
	input  wire logic        busWr,
	input  wire logic        busRd,
	output logic [7:0]       busRdata,
	// System mode, same clock domain
	input  wire logic        stopMode,
	// Array and pump controls
	output logic             pumpClockSel,
	output logic             arrayPowerDown,
	output logic             chargePumpOn,
	output logic [1:0]       configBits
);

	////////////////////////////////////////////////////////////////////////////
	// State

	logic             pcs_reg,        pcs_next;
	logic             off_reg,        off_next;
	logic [1:0]       erase_reg,      erase_next;
	logic             latch_reg,      latch_next;
	logic             hv_reg,         hv_next;
	logic             latchValid_reg, latchValid_next;
	eep_pkg::eep_wr_t latched_reg,    latched_next;
	logic [7:0]       nv_reg,         nv_next;
	logic [7:0]       shadow_reg,     shadow_next;
	logic [7:0]       rdata_reg,      rdata_next;
	logic             pumpOn_reg,     pumpOn_next;

	////////////////////////////////////////////////////////////////////////////
	// Decode

	logic [15:0]      arrDelta;
	logic [AW-1:0]    offs;
	logic             inArray;
	logic             hitNv;
	logic             hitCtrl;
	logic             hitShadow;
	logic             ctrlWr;
	logic             arrWr;
	logic [7:0]       nvView;
	logic [7:0]       nvErased;
	logic [7:0]       ctrlView;
	logic [7:0]       arrRd;
	logic             allow;
	logic             reqSecure;
	eep_pkg::eep_wr_t request;
	eep_pkg::eep_op_t opNext;
	eep_pkg::eep_op_t opNow;

	assign arrDelta  = busAddr - `EEP_ARRAY_BASE;
	assign offs      = arrDelta[AW-1:0];
	assign inArray   = (busAddr >= `EEP_ARRAY_BASE) && (arrDelta < 16'((1<<AW)));
	assign hitNv     = (busAddr == `EEP_ADDR_NV);
	assign hitCtrl   = (busAddr == `EEP_ADDR_CTRL);
	assign hitShadow = (busAddr == `EEP_ADDR_SHADOW);
	assign ctrlWr    = busWr && hitCtrl;
	assign request   = '{isNv: hitNv, offs: hitNv ? '0 : offs, data: busWdata};
	assign opNext    = eep_pkg::eep_op_t'(erase_next);
	assign opNow     = eep_pkg::eep_op_t'(erase_reg);

	// Reserved bit is not stored as a one on the way out
	assign nvView    = {1'b0, nv_reg[`EEP_NV_RSVD-1:0]}; // see (RULE11)

	always_comb begin
		ctrlView                 = `EEP_CTRL_RESET;
		ctrlView[`EEP_CTRL_PCS]  = pcs_reg;
		ctrlView[`EEP_CTRL_OFF]  = off_reg;
		ctrlView[`EEP_CTRL_ERH]  = erase_reg[1];
		ctrlView[`EEP_CTRL_ERL]  = erase_reg[0];
		ctrlView[`EEP_CTRL_LAT]  = latch_reg;
		ctrlView[`EEP_CTRL_HV]   = hv_reg;
		nvErased                 = `EEP_NV_ERASED;
		// An armed lock bit never returns to one, even through an erase
		nvErased[`EEP_NV_LOCK]   = nv_reg[`EEP_NV_LOCK]; // see (RULE13)
	end

	////////////////////////////////////////////////////////////////////////////
	// Protection and storage

	eep_protect #(.AW(AW), .BW(BW)) u_reqProt (
		.target   (request),
		.op       (opNow),
		.shadow   (shadow_reg),
		.allow    (),
		.inSecure (reqSecure)
	);

	eep_protect #(.AW(AW), .BW(BW)) u_hvProt (
		.target   (latched_next),
		.op       (opNext),
		.shadow   (shadow_reg),
		.allow    (allow),
		.inSecure ()
	);

	eep_array #(.AW(AW), .BW(BW)) u_array (
		.clk    (clk),
		.por    (por),
		.rdOffs (offs),
		.rdData (arrRd),
		.apply  (pumpOn_reg && !latched_reg.isNv),
		.op     (opNow),
		.offs   (latched_reg.offs),
		.data   (latched_reg.data)
	);

	// With the lock armed a write to the top bytes does not count as a latched write
	// Latched target is frozen while high voltage is enabled
	assign arrWr = busWr && latch_reg && !hv_reg && (inArray || hitNv) &&
		!(!shadow_reg[`EEP_NV_LOCK] && inArray && reqSecure); // see (RULE7) see (RULE13)

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		pcs_next        = pcs_reg;
		off_next        = off_reg;
		erase_next      = erase_reg;
		latch_next      = latch_reg;
		hv_next         = hv_reg;
		latchValid_next = latchValid_reg;
		latched_next    = latched_reg;
		nv_next         = nv_reg;
		shadow_next     = shadow_reg;
		rdata_next      = `EEP_RD_IDLE;
		if (arrWr) begin
			// A later valid write overrides the earlier one
			latched_next    = request;
			latchValid_next = 1'b1;
		end
		if (ctrlWr) begin
			pcs_next = busWdata[`EEP_CTRL_PCS]; // see (RULE1)
			off_next = busWdata[`EEP_CTRL_OFF]; // see (RULE3)
			if (!hv_reg) begin
				erase_next = {busWdata[`EEP_CTRL_ERH], busWdata[`EEP_CTRL_ERL]}; // see (RULE5)
			end
			latch_next = busWdata[`EEP_CTRL_LAT] || hv_reg; // see (RULE8) see (RULE10)
			hv_next    = busWdata[`EEP_CTRL_HV] && latch_next && latchValid_reg; // see (RULE9)
			if (!latch_next) begin
				latchValid_next = 1'b0;
			end
		end
		if (pumpOn_reg && latched_reg.isNv) begin
			if (opNow == eep_pkg::EEP_OP_PROGRAM) begin
				nv_next = nv_reg & latched_reg.data;
			end else begin
				nv_next = nvErased;
			end
		end
		if (busRd && hitNv) begin
			shadow_next = nvView; // see (RULE20)
		end
		if (busRd) begin
			if (hitCtrl) begin
				rdata_next = ctrlView;
			end else if (hitNv) begin
				rdata_next = nvView;
			end else if (hitShadow) begin
				rdata_next = shadow_reg;
			end else if (inArray && off_reg) begin
				// Powered-down array gives a fixed value rather than garbage
				rdata_next = `EEP_RD_IDLE;
			end else if (inArray && latch_reg && latchValid_reg) begin
				rdata_next = latched_reg.data; // see (RULE19)
			end else if (inArray) begin
				rdata_next = arrRd;
			end
		end
		// Wait mode has no term here, so an operation keeps running through it
		pumpOn_next = hv_next && latch_next && latchValid_next && allow && !stopMode; // see (RULE14) see (RULE16)
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge clk) begin
		if (por) begin
			nv_reg <= `EEP_NV_ERASED;
		end else begin
			nv_reg <= nv_next;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || por) begin
			pcs_reg        <= 1'b0;
			off_reg        <= 1'b0;
			erase_reg      <= 2'h0;
			latch_reg      <= 1'b0;
			hv_reg         <= 1'b0;
			latchValid_reg <= 1'b0;
			latched_reg    <= '0;
			rdata_reg      <= `EEP_RD_IDLE;
			pumpOn_reg     <= 1'b0;
		end else begin
			pcs_reg        <= pcs_next;
			off_reg        <= off_next;
			erase_reg      <= erase_next;
			latch_reg      <= latch_next;
			hv_reg         <= hv_next;
			latchValid_reg <= latchValid_next;
			latched_reg    <= latched_next;
			rdata_reg      <= rdata_next;
			pumpOn_reg     <= pumpOn_next;
		end
	end

	// Synchronous reset, so sampling the stored byte here is a clocked load
	always_ff @(posedge clk) begin
		if (rst || por) begin
			shadow_reg <= nvView; // see (RULE12)
		end else begin
			shadow_reg <= shadow_next;
		end
	end

	assign busRdata       = rdata_reg;
	assign pumpClockSel   = pcs_reg;
	assign arrayPowerDown = off_reg;
	assign chargePumpOn   = pumpOn_reg;
	assign configBits     = shadow_reg[`EEP_NV_CFGH:`EEP_NV_CFGL];

	////////////////////////////////////////////////////////////////////////////
	// Checks

	a_pump_clk_sel: assert property (@(posedge clk) disable iff (rst || por) // see (RULE1)
		ctrlWr |=> pcs_reg == $past(busWdata[`EEP_CTRL_PCS]))
		else $error("pump clock select did not follow write");

	a_reset_clears: assert property (@(posedge clk) disable iff (por) // see (RULE5)
		rst |=> !pcs_reg && !off_reg && erase_reg == 2'h0 && !latch_reg && !hv_reg)
		else $error("control bits not cleared by reset");

	a_latch_held_hv: assert property (@(posedge clk) disable iff (rst || por) // see (RULE8)
		hv_reg && ctrlWr && !busWdata[`EEP_CTRL_LAT] |=> latch_reg)
		else $error("latch cleared while high voltage enabled");

	a_clear_both: assert property (@(posedge clk) disable iff (rst || por) // see (RULE10)
		hv_reg && ctrlWr && !busWdata[`EEP_CTRL_LAT] && !busWdata[`EEP_CTRL_HV] |=> latch_reg && !hv_reg)
		else $error("double clear did not clear only high voltage");

	a_hv_needs_latch: assert property (@(posedge clk) disable iff (rst || por) // see (RULE9)
		!hv_reg ##1 hv_reg |-> latch_reg && latchValid_reg && $past(latchValid_reg))
		else $error("high voltage enabled without latched write");

	a_stop_hv_off: assert property (@(posedge clk) disable iff (rst || por) // see (RULE16)
		stopMode && hv_reg && !ctrlWr |=> !chargePumpOn && hv_reg)
		else $error("stop did not remove high voltage or lost enable");

	a_stop_resume: assert property (@(posedge clk) disable iff (rst || por) // see (RULE16)
		$past(stopMode) && !stopMode && hv_reg && !ctrlWr && allow |=> chargePumpOn)
		else $error("high voltage not restored after stop");

	a_protect_gate: assert property (@(posedge clk) disable iff (rst || por) // see (RULE6)
		chargePumpOn |-> $past(allow) && $past(hv_next))
		else $error("pump on for protected target");

	a_secure_top: assert property (@(posedge clk) disable iff (rst || por) // see (RULE13)
		chargePumpOn && !$past(shadow_reg[`EEP_NV_LOCK]) |-> !latched_reg.isNv &&
			!(&latched_reg.offs[AW-1:`EEP_SECURE_W]) && erase_reg[1] == 1'b0)
		else $error("secure region reached by high voltage");

	a_lock_sticky: assert property (@(posedge clk) disable iff (por) // see (RULE13)
		!nv_reg[`EEP_NV_LOCK] |=> !nv_reg[`EEP_NV_LOCK])
		else $error("lock bit returned to one");

	a_shadow_reload: assert property (@(posedge clk) disable iff (rst || por) // see (RULE20)
		busRd && hitNv |=> shadow_reg == {1'b0, $past(nv_reg[6:0])} && busRdata[7] == 1'b0)
		else $error("config read did not reload shadow");

	a_read_latched: assert property (@(posedge clk) disable iff (rst || por) // see (RULE19)
		busRd && inArray && latch_reg && latchValid_reg && !off_reg |=> busRdata == $past(latched_reg.data))
		else $error("latched read returned stored data");

endmodule

/* File: rtl/eep_protect.sv */
`timescale 1ns/1ps
`include "eep_consts.svh"

module eep_protect #(
	parameter int AW = `EEP_OFFS_W,
	parameter int BW = `EEP_BLOCK_W,
	parameter int SW = `EEP_SECURE_W
) (
	// Target and mode
	input  wire eep_pkg::eep_wr_t target,
	input  wire eep_pkg::eep_op_t op,
	// Effective configuration
	input  wire logic [7:0]       shadow,
	// Result
	output logic                  allow,
	output logic                  inSecure
);

	logic [3:0] bp;
	logic       secure;
	logic       blkProt;

	always_comb begin
		bp       = shadow[`EEP_NV_BPH:`EEP_NV_BPL];
		secure   = !shadow[`EEP_NV_LOCK];
		inSecure = &target.offs[AW-1:SW];
		blkProt  = bp[target.offs[AW-1:BW]];
		allow    = 1'b0;
		if (target.isNv) begin
			// Block and bulk erase never touch the configuration byte
			allow = !secure && (op == eep_pkg::EEP_OP_PROGRAM || op == eep_pkg::EEP_OP_BYTE_ERASE); // see (RULE13)
		end else begin
			case (op)
				eep_pkg::EEP_OP_PROGRAM,
				eep_pkg::EEP_OP_BYTE_ERASE: begin
					allow = !blkProt && !(secure && inSecure); // see (RULE6) see (RULE13)
				end
				eep_pkg::EEP_OP_BLOCK_ERASE: begin
					allow = !blkProt && !secure; // see (RULE21)
				end
				eep_pkg::EEP_OP_BULK_ERASE: begin
					allow = (bp == 4'h0) && !secure; // see (RULE6)
				end
				default: begin
					allow = 1'b0;
				end
			endcase
		end
	end

endmodule

/* File: sim/testbench.sv */
`timescale 1ns/1ps
`include "eep_consts.svh"

module testbench;

	typedef struct {
		int         sel;
		logic [7:0] exp;
	} eep_note_t;

	logic        clk;
	logic        rst;
	logic        por;
	logic [15:0] busAddr;
	logic [7:0]  busWdata;
	logic        busWr;
	logic        busRd;
	logic [7:0]  busRdata;
	logic        stopMode;
	logic        pumpClockSel;
	logic        arrayPowerDown;
	logic        chargePumpOn;
	logic [1:0]  configBits;
	int          lookSel;
	logic        rdPend;
	int          err_total;
	int          checks;
	eep_note_t   notes[$];
	logic [7:0]  v;

	eep_prog_erase_ctrl i_eep_prog_erase_ctrl (
		.clk            (clk),
		.rst            (rst),
		.por            (por),
		.busAddr        (busAddr),
		.busWdata       (busWdata),
		.busWr          (busWr),
		.busRd          (busRd),
		.busRdata       (busRdata),
		.stopMode       (stopMode),
		.pumpClockSel   (pumpClockSel),
		.arrayPowerDown (arrayPowerDown),
		.chargePumpOn   (chargePumpOn),
		.configBits     (configBits)
	);

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic end_of_test();
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One call per clock: every bus input and lookSel is assigned once per edge, so back to back calls never collide
	task automatic cyc(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d,
		input int sel, input logic [7:0] e);
		@(posedge clk);
		busWr    <= w;
		busRd    <= r;
		busAddr  <= a;
		busWdata <= d;
		lookSel  <= sel;
		if (r || sel != 0) begin
			notes.push_back('{sel: sel, exp: e});
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		cyc(1'b1, 1'b0, a, d, 0, 8'h00);
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		cyc(1'b0, 1'b1, a, 8'h00, 0, e);
	endtask

	task automatic look(input int sel, input logic [7:0] e);
		cyc(1'b0, 1'b0, 16'h0000, 8'h00, sel, e);
	endtask

	// Latch, write target, raise high voltage, drop it, then drop the latch
	task automatic op(input logic [1:0] mode, input logic [15:0] a, input logic [7:0] d,
		input int sel, input logic [7:0] pump);
		wr(`EEP_ADDR_CTRL, {3'h0, mode, 3'h4});
		wr(a, d);
		wr(`EEP_ADDR_CTRL, {3'h0, mode, 3'h5});
		look(sel, pump);
		wr(`EEP_ADDR_CTRL, {3'h0, mode, 3'h4});
		wr(`EEP_ADDR_CTRL, 8'h00);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Outputs are sampled at the edge, so they show the cycle that just ended
	always @(posedge clk) begin
		eep_note_t n;
		if (rdPend === 1'b1) begin
			n = notes.pop_front();
			chk("busRdata", busRdata, n.exp);
		end
		if (lookSel != 0) begin
			n = notes.pop_front();
			case (lookSel)
				1: chk("pumpClockSel", {7'h0, pumpClockSel}, n.exp);
				2: chk("arrayPowerDown", {7'h0, arrayPowerDown}, n.exp);
				3: chk("chargePumpOn", {7'h0, chargePumpOn}, n.exp);
				default: chk("configBits", {6'h0, configBits}, n.exp);
			endcase
		end
		rdPend <= busRd;
	end

	initial begin
		repeat (5000) @(posedge clk);
		err_total++;
		end_of_test();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1; por = 1'b1; busAddr = 16'h0; busWdata = 8'h0; busWr = 1'b0; busRd = 1'b0;
		stopMode = 1'b0; lookSel = 0; rdPend = 1'b0; err_total = 0; checks = 0;
		v = 8'($urandom(56821));
		repeat (4) @(posedge clk);
		por <= 1'b0;
		rst <= 1'b0;
		rd(`EEP_ADDR_CTRL, 8'h00);
		rd(`EEP_ADDR_NV, 8'h7f);
		rd(`EEP_ADDR_SHADOW, 8'h7f);
		look(4, 8'h03);
		wr(16'hfe1a, 8'hff);
		rd(16'hfe1a, 8'h00);
		wr(`EEP_ADDR_SHADOW, 8'h00);
		rd(`EEP_ADDR_SHADOW, 8'h7f);
		repeat (6) begin
			v = 8'($urandom) & 8'hb8;
			wr(`EEP_ADDR_CTRL, v);
			rd(`EEP_ADDR_CTRL, v);
			look(1, {7'h0, v[7]});
			look(2, {7'h0, v[5]});
		end
		wr(`EEP_ADDR_CTRL, 8'h20);
		rd(16'h0600, 8'h00);
		wr(`EEP_ADDR_CTRL, 8'h00);
		repeat (2) look(0, 8'h00);
		// Erased config byte protects every block, so clear the protect bits first
		op(2'b00, `EEP_ADDR_NV, 8'h50, 0, 8'h00);
		rd(`EEP_ADDR_NV, 8'h50);
		look(4, 8'h02);
		// Plain program with the latch and refusal paths
		v = 8'($urandom);
		wr(`EEP_ADDR_CTRL, 8'h04);
		wr(16'h0600, v);
		rd(16'h0700, v);
		wr(`EEP_ADDR_CTRL, 8'h05);
		look(3, 8'h01);
		wr(`EEP_ADDR_CTRL, 8'h01);
		rd(`EEP_ADDR_CTRL, 8'h05);
		wr(`EEP_ADDR_CTRL, 8'h00);
		rd(`EEP_ADDR_CTRL, 8'h04);
		look(3, 8'h00);
		wr(`EEP_ADDR_CTRL, 8'h00);
		rd(`EEP_ADDR_CTRL, 8'h00);
		rd(16'h0600, v);
		wr(`EEP_ADDR_CTRL, 8'h04);
		wr(`EEP_ADDR_CTRL, 8'h05);
		rd(`EEP_ADDR_CTRL, 8'h04);
		look(3, 8'h00);
		wr(`EEP_ADDR_CTRL, 8'h00);
		// Every mode once, program twice
		op(2'b00, 16'h0680, 8'h3c, 3, 8'h01);
		op(2'b01, 16'h0600, 8'h00, 3, 8'h01);
		rd(16'h0600, 8'hff);
		op(2'b00, 16'h0600, 8'ha5, 0, 8'h00);
		op(2'b10, 16'h0610, 8'h00, 3, 8'h01);
		rd(16'h0600, 8'hff);
		rd(16'h0680, 8'h3c);
		op(2'b11, 16'h0700, 8'h00, 3, 8'h01);
		rd(16'h0680, 8'hff);
		// Block protect through the config byte; programming only clears bits, so erase first
		op(2'b01, `EEP_ADDR_NV, 8'h00, 0, 8'h00);
		op(2'b00, `EEP_ADDR_NV, 8'h72, 0, 8'h00);
		rd(`EEP_ADDR_NV, 8'h72);
		rd(`EEP_ADDR_SHADOW, 8'h72);
		op(2'b00, 16'h0680, 8'h00, 3, 8'h00);
		rd(16'h0680, 8'hff);
		op(2'b00, 16'h0600, 8'h00, 3, 8'h01);
		op(2'b11, 16'h0600, 8'h00, 0, 8'h00);
		rd(16'h0600, 8'h00);
		// Security lock
		op(2'b01, `EEP_ADDR_NV, 8'h00, 0, 8'h00);
		rd(`EEP_ADDR_NV, 8'h7f);
		op(2'b00, `EEP_ADDR_NV, 8'h60, 0, 8'h00);
		rd(`EEP_ADDR_NV, 8'h60);
		op(2'b00, 16'h07ff, 8'h00, 3, 8'h00);
		rd(16'h07ff, 8'hff);
		op(2'b00, 16'h07ef, 8'h00, 3, 8'h01);
		rd(16'h07ef, 8'h00);
		op(2'b01, `EEP_ADDR_NV, 8'h00, 0, 8'h00);
		rd(`EEP_ADDR_NV, 8'h60);
		// Stop in mid-program
		wr(`EEP_ADDR_CTRL, 8'h04);
		wr(16'h0680, 8'h11);
		wr(`EEP_ADDR_CTRL, 8'h05);
		look(3, 8'h01);
		stopMode <= 1'b1;
		look(0, 8'h00);
		look(3, 8'h00);
		rd(`EEP_ADDR_CTRL, 8'h05);
		stopMode <= 1'b0;
		look(0, 8'h00);
		look(3, 8'h01);
		wr(`EEP_ADDR_CTRL, 8'h04);
		wr(`EEP_ADDR_CTRL, 8'h00);
		// Second reset keeps storage and reloads the shadow
		look(0, 8'h00);
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd(`EEP_ADDR_CTRL, 8'h00);
		rd(`EEP_ADDR_SHADOW, 8'h60);
		look(4, 8'h03);
		rd(16'h0680, 8'h11);
		repeat (3) look(0, 8'h00);
		end_of_test();
	end

endmodule
